//--- hw/tcd_consts.svh
// constants of the two-channel cycle-steal transfer controller
// Operation
// R1: two channels, channel zero wins ties
// R2: any-to-fixed, fixed-to-any, fixed-to-fixed in 1M
// R3: register block 002016-003F16 never accessed
// R4: 8/16-bit units, 64K/128K bytes per activation
// R5: selectable request source per channel
// R6: both sides incrementing is refused
// R7: single mode clears enable on underflow
// R8: repeat mode reloads counter, stays active
// R9: interrupt request at counter underflow
// R10: enabled channel transfers on every request
// R11: first transfer loads pointer and counter
// R12: fixed pointers writable only while disabled
// R13: reads anytime, live pointer while enabled
// R14: requests ignore processor interrupt masking
// R15: source reads, then destination writes
// R16: odd 16-bit unit takes extra cycles
// R17: 8-bit bus splits 16-bit units
// R18: bus-width pin sets internal access width
// R19: peripheral or waited access adds one cycle
// R20: request bit set always, cleared at start
// R21: writing enable again restarts channel
// R22: processor gets one access between channels
// R23: 16-bit counter underflows past zero
// R24: software request bit write pulses request
`ifndef TCD_CONSTS_SVH
`define TCD_CONSTS_SVH
// ----------------------------------------------------------------
// address space
// ----------------------------------------------------------------
`define TCD_BLK_LO 20'h00020
`define TCD_BLK_HI 20'h0003f
`define TCD_PERI_HI 20'h003ff
// ----------------------------------------------------------------
// register indices, regAddr[3] picks the channel
// ----------------------------------------------------------------
`define TCD_R_SLO 3'h0
`define TCD_R_SHI 3'h1
`define TCD_R_DLO 3'h2
`define TCD_R_DHI 3'h3
`define TCD_R_RLD 3'h4
`define TCD_R_CNT 3'h5
`define TCD_R_CTL 3'h6
`define TCD_R_SEL 3'h7
// ----------------------------------------------------------------
// control bits and request source codes
// ----------------------------------------------------------------
`define TCD_C_EN 0
`define TCD_C_RPT 1
`define TCD_C_U16 2
`define TCD_C_SINC 3
`define TCD_C_DINC 4
`define TCD_C_REQ 5
`define TCD_C_SWR 6
`define TCD_C_WT 7
`define TCD_S_PF 4'h1
`define TCD_S_PB 4'h2
`define TCD_S_PLO 4'h4
`define TCD_S_PHI 4'hb
`endif

//--- hw/tcd_pkg.sv
// types of the two-channel cycle-steal transfer controller
package tcd_pkg;
  typedef enum logic [3:0] {
    IDLE = 4'b0001,
    RD = 4'b0010,
    WR = 4'b0100,
    GAP = 4'b1000
  } tcd_fsm_t;
  // system bus request driven by the controller
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic rd;
    logic wr;
    logic wide;
  } tcd_mem_t;
  typedef struct packed {
    logic [19:0] srcPtr;
    logic [19:0] dstPtr;
    logic [19:0] live;
    logic [15:0] reload;
    logic [15:0] count;
    logic en, rpt, u16, sInc, dInc, wt, req, fresh, pinPrev;
    logic [3:0] sel;
  } tcd_chan_t;
  typedef struct packed {
    tcd_fsm_t fsm;
    tcd_chan_t [1:0] ch;
    tcd_mem_t mem;
    logic [19:0] src;
    logic [19:0] dst;
    logic [15:0] data;
    logic cur, beat, two, wl, busReq;
    logic [1:0] irq;
    logic [15:0] rdata;
  } tcd_state_t;
endpackage

//--- hw/tcd_top.sv
// two-channel cycle-steal transfer controller
//
// Design decisions made here: the address map and the strobed register port.
`include "tcd_consts.svh"
module tcd_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic [7:0] periReq,
  input wire logic extIrqPinZero,
  input wire logic extIrqPinOne,
  input wire logic expMode,
  input wire logic byteBus,
  input wire logic [15:0] memRdata,
  output tcd_pkg::tcd_mem_t memBus,
  output logic busReq,
  output logic [1:0] dmaIrq
);
  import tcd_pkg::*;

  tcd_state_t st_q, st_d;
  logic [1:0] pins;
  logic bus8;
  logic endXfer;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // register block guard: the controller must not touch itself
  function automatic logic inBlk(input logic [19:0] a);
    inBlk = (a >= `TCD_BLK_LO) && (a <= `TCD_BLK_HI);
  endfunction

  // peripheral area, or any area while software wait is on
  function automatic logic waitOf(input logic [19:0] a, input logic wt);
    waitOf = (a <= `TCD_PERI_HI) || wt;
  endfunction

  // a 16-bit unit splits on an 8-bit bus or an odd start
  function automatic logic twoOf(input logic [19:0] a, input logic u16,
                                 input logic b8);
    twoOf = u16 && (b8 || a[0]);
  endfunction

  function automatic logic reqHit(input logic [3:0] sel, input logic pin,
                                  input logic prev, input logic [7:0] per);
    case (sel)
      `TCD_S_PF: reqHit = prev && !pin;
      `TCD_S_PB: reqHit = prev ^ pin;
      default: reqHit = (sel >= `TCD_S_PLO) && (sel <= `TCD_S_PHI) &&
                        per[sel[2:0] ^ 3'h4];
    endcase
  endfunction

  assign pins = {extIrqPinOne, extIrqPinZero};
  // width pin only counts outside single-chip mode, internal memory too
  assign bus8 = expMode && byteBus; // [R17] [R18]
  assign endXfer = (st_q.fsm == WR) && !st_q.wl && (!st_q.two || st_q.beat);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic c;
    logic [19:0] a;
    logic [19:0] step;
    c = 1'b0;
    a = '0;
    step = '0;
    st_d = st_q;
    st_d.irq = 2'b00;
    st_d.rdata = 16'h0000;
    // transfer sequencer; no processor mask is consulted [R14]
    case (st_q.fsm)
      IDLE: begin
        if ((st_q.ch[0].en && st_q.ch[0].req) ||
            (st_q.ch[1].en && st_q.ch[1].req)) begin // [R10]
          c = !(st_q.ch[0].en && st_q.ch[0].req); // [R1]
          st_d.cur = c;
          st_d.ch[c].req = 1'b0; // [R20]
          st_d.ch[c].fresh = 1'b0;
          if (st_q.ch[c].fresh) begin
            st_d.ch[c].count = st_q.ch[c].reload; // [R11]
          end
          // the incrementing side runs from the live pointer [R2]
          st_d.src = (st_q.ch[c].sInc && !st_q.ch[c].fresh) ?
                     st_q.ch[c].live : st_q.ch[c].srcPtr; // [R11]
          st_d.dst = (st_q.ch[c].dInc && !st_q.ch[c].fresh) ?
                     st_q.ch[c].live : st_q.ch[c].dstPtr;
          st_d.two = twoOf(st_d.src, st_q.ch[c].u16, bus8); // [R16]
          st_d.beat = 1'b0;
          st_d.mem.addr = st_d.src;
          st_d.mem.rd = !inBlk(st_d.src); // [R3]
          st_d.mem.wr = 1'b0;
          st_d.mem.wide = st_q.ch[c].u16 && !st_d.two;
          st_d.wl = waitOf(st_d.src, st_q.ch[c].wt);
          st_d.busReq = 1'b1;
          st_d.fsm = RD; // [R15]
        end
      end
      RD: begin
        c = st_q.cur;
        if (st_q.wl) begin
          st_d.wl = 1'b0; // [R19]
        end else begin
          if (st_q.two) begin
            st_d.data[{st_q.beat, 3'h0} +: 8] = memRdata[7:0];
          end else if (st_q.ch[c].u16) begin
            st_d.data = memRdata;
          end else begin
            st_d.data = {8'h00, memRdata[7:0]};
          end
          if (st_q.two && !st_q.beat) begin
            // second byte of a split unit [R16] [R17]
            a = st_q.src + 20'h00001;
            st_d.beat = 1'b1;
            st_d.mem.addr = a;
            st_d.mem.rd = !inBlk(a);
            st_d.wl = waitOf(a, st_q.ch[c].wt);
          end else begin
            // reads done, destination writes follow [R15]
            st_d.two = twoOf(st_q.dst, st_q.ch[c].u16, bus8);
            st_d.beat = 1'b0;
            st_d.mem.addr = st_q.dst;
            st_d.mem.rd = 1'b0;
            st_d.mem.wr = !inBlk(st_q.dst); // [R3]
            st_d.mem.wide = st_q.ch[c].u16 && !st_d.two;
            st_d.mem.wdata = st_d.two ? {8'h00, st_d.data[7:0]} : st_d.data;
            st_d.wl = waitOf(st_q.dst, st_q.ch[c].wt);
            st_d.fsm = WR;
          end
        end
      end
      WR: begin
        c = st_q.cur;
        if (st_q.wl) begin
          st_d.wl = 1'b0; // [R19]
        end else if (st_q.two && !st_q.beat) begin
          a = st_q.dst + 20'h00001;
          st_d.beat = 1'b1;
          st_d.mem.addr = a;
          st_d.mem.wr = !inBlk(a);
          st_d.mem.wdata = {8'h00, st_q.data[15:8]};
          st_d.wl = waitOf(a, st_q.ch[c].wt);
        end else begin
          st_d.mem.wr = 1'b0;
          st_d.busReq = 1'b0;
          step = {18'h00000, st_q.ch[c].u16, !st_q.ch[c].u16}; // [R4]
          if (st_q.ch[c].sInc || st_q.ch[c].dInc) begin
            st_d.ch[c].live = (st_q.ch[c].sInc ? st_q.src : st_q.dst) + step;
          end
          // counter passing zero is the underflow [R23]
          if (st_q.ch[c].count == 16'h0000) begin
            st_d.irq[c] = 1'b1; // [R9]
            if (st_q.ch[c].rpt) begin
              st_d.ch[c].count = st_q.ch[c].reload; // [R8]
            end else begin
              st_d.ch[c].en = 1'b0; // [R7]
            end
          end else begin
            st_d.ch[c].count = st_q.ch[c].count - 16'h0001;
          end
          // channel zero hands the bus back before anyone else [R22]
          st_d.fsm = c ? IDLE : GAP;
        end
      end
      GAP: begin
        st_d.fsm = IDLE; // [R22]
      end
      default: begin
        st_d.fsm = IDLE;
      end
    endcase

    // software writes; they override the sequencer's own updates
    if (regWr) begin
      c = regAddr[3];
      case (regAddr[2:0])
        `TCD_R_SLO: begin
          if (st_q.ch[c].sInc || !st_q.ch[c].en) begin
            st_d.ch[c].srcPtr[15:0] = regWdata; // [R12]
          end
        end
        `TCD_R_SHI: begin
          if (st_q.ch[c].sInc || !st_q.ch[c].en) begin
            st_d.ch[c].srcPtr[19:16] = regWdata[3:0]; // [R12]
          end
        end
        `TCD_R_DLO: begin
          if (st_q.ch[c].dInc || !st_q.ch[c].en) begin
            st_d.ch[c].dstPtr[15:0] = regWdata; // [R12]
          end
        end
        `TCD_R_DHI: begin
          if (st_q.ch[c].dInc || !st_q.ch[c].en) begin
            st_d.ch[c].dstPtr[19:16] = regWdata[3:0]; // [R12]
          end
        end
        `TCD_R_RLD: begin
          st_d.ch[c].reload = regWdata;
        end
        `TCD_R_CTL: begin
          st_d.ch[c].en = regWdata[`TCD_C_EN];
          st_d.ch[c].fresh = regWdata[`TCD_C_EN]; // [R21] [R11]
          st_d.ch[c].rpt = regWdata[`TCD_C_RPT];
          st_d.ch[c].u16 = regWdata[`TCD_C_U16]; // [R4]
          st_d.ch[c].wt = regWdata[`TCD_C_WT];
          st_d.ch[c].sInc = regWdata[`TCD_C_SINC];
          // source wins when both sides ask to increment [R6]
          st_d.ch[c].dInc = regWdata[`TCD_C_DINC] && !regWdata[`TCD_C_SINC];
          if (!regWdata[`TCD_C_REQ]) begin
            st_d.ch[c].req = 1'b0; // [R20]
          end
        end
        `TCD_R_SEL: begin
          st_d.ch[c].sel = regWdata[3:0]; // [R5]
        end
        default: begin
          st_d.ch[c].sel = st_q.ch[c].sel;
        end
      endcase
    end

    // register reads, answered on the next cycle [R13]
    if (regRd) begin
      c = regAddr[3];
      case (regAddr[2:0])
        `TCD_R_SLO: st_d.rdata = (st_q.ch[c].en && st_q.ch[c].sInc) ?
                                 st_q.ch[c].live[15:0] : st_q.ch[c].srcPtr[15:0];
        `TCD_R_SHI: st_d.rdata = {12'h000, (st_q.ch[c].en && st_q.ch[c].sInc) ?
                                 st_q.ch[c].live[19:16] : st_q.ch[c].srcPtr[19:16]};
        `TCD_R_DLO: st_d.rdata = (st_q.ch[c].en && st_q.ch[c].dInc) ?
                                 st_q.ch[c].live[15:0] : st_q.ch[c].dstPtr[15:0];
        `TCD_R_DHI: st_d.rdata = {12'h000, (st_q.ch[c].en && st_q.ch[c].dInc) ?
                                 st_q.ch[c].live[19:16] : st_q.ch[c].dstPtr[19:16]};
        `TCD_R_RLD: st_d.rdata = st_q.ch[c].reload;
        `TCD_R_CNT: st_d.rdata = st_q.ch[c].count;
        `TCD_R_CTL: st_d.rdata = {8'h00, st_q.ch[c].wt, 1'b0, st_q.ch[c].req,
                                 st_q.ch[c].dInc, st_q.ch[c].sInc, st_q.ch[c].u16,
                                 st_q.ch[c].rpt, st_q.ch[c].en};
        default: st_d.rdata = {12'h000, st_q.ch[c].sel};
      endcase
    end

    // requests last, so a new one beats any clear in the same cycle
    for (int i = 0; i < 2; i++) begin
      st_d.ch[i].pinPrev = pins[i];
      if (reqHit(st_q.ch[i].sel, pins[i], st_q.ch[i].pinPrev, periReq) ||
          (regWr && regAddr == {i[0], `TCD_R_CTL} && regWdata[`TCD_C_SWR])) begin
        st_d.ch[i].req = 1'b1; // [R20] [R24] [R5]
      end
    end
  end

  // ----------------------------------------------------------------
  // state register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_q <= '0;
      st_q.fsm <= IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign regRdata = st_q.rdata;
  assign memBus = st_q.mem;
  assign busReq = st_q.busReq;
  assign dmaIrq = st_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence sBoth;
    st_q.fsm == IDLE && st_q.ch[0].en && st_q.ch[0].req &&
      st_q.ch[1].en && st_q.ch[1].req;
  endsequence
  sequence sHandBack;
    st_q.fsm == GAP && !busReq ##1 st_q.fsm == IDLE;
  endsequence
  sequence sPeriRd;
    $rose(memBus.rd) && memBus.addr <= `TCD_PERI_HI;
  endsequence

  AST_PRIO: assert property (sBoth |=> st_q.fsm == RD && !st_q.cur) // [R1]
    else $error("channel one served before channel zero");

  AST_GAP: assert property (endXfer && !st_q.cur |=> sHandBack) // [R22]
    else $error("no processor slot after channel zero");

  AST_GUARD: assert property ((memBus.rd || memBus.wr) |-> !inBlk(memBus.addr)) // [R3]
    else $error("strobe into the controller register block");

  AST_DIR: assert property (!(st_q.ch[0].sInc && st_q.ch[0].dInc) && // [R6]
                            !(st_q.ch[1].sInc && st_q.ch[1].dInc))
    else $error("both sides incrementing");

  AST_SINGLE: assert property (endXfer && st_q.ch[st_q.cur].count == 16'h0000 && // [R7]
                               !st_q.ch[st_q.cur].rpt && !regWr |=>
                               !st_q.ch[$past(st_q.cur)].en)
    else $error("single mode stayed enabled after underflow");

  // either channel may run in repeat mode
  AST_RPT: assert property (endXfer && st_q.ch[st_q.cur].count == 16'h0000 && // [R8]
                            st_q.ch[st_q.cur].rpt && !regWr |=>
                            st_q.ch[$past(st_q.cur)].count ==
                            $past(st_q.ch[st_q.cur].reload) && st_q.ch[$past(st_q.cur)].en)
    else $error("repeat mode did not reload");

  AST_IRQ: assert property (endXfer && st_q.cur && st_q.ch[1].count == 16'h0000 // [R9]
                            |=> dmaIrq[1] ##1 !dmaIrq[1])
    else $error("underflow interrupt not a single pulse");

  AST_WAIT: assert property (sPeriRd |-> memBus.rd [*2]) // [R19]
    else $error("peripheral access not stretched");

  AST_CNTRD: assert property (regRd && regAddr == {1'b0, `TCD_R_CNT} |=> // [R13]
                              regRdata == $past(st_q.ch[0].count))
    else $error("counter read mismatch");

  // with channel one enabled and its flag up, a transfer holds the bus next cycle
  AST_GO: assert property (st_q.fsm == IDLE && st_q.ch[1].en && st_q.ch[1].req |=> // [R10]
                           st_q.fsm == RD && busReq)
    else $error("enabled channel ignored its request");

  // with both channels disabled the bus stays with the processor
  AST_IDLE: assert property (st_q.fsm == IDLE && !st_q.ch[0].en && !st_q.ch[1].en |=> // [R10]
                             !busReq)
    else $error("disabled channel started a transfer");

  // the start clears the flag when no new request can arrive
  AST_REQCLR: assert property (st_q.fsm == IDLE && st_q.ch[0].en && st_q.ch[0].req && // [R20]
                               st_q.ch[0].sel == 4'h0 && !regWr |=> !st_q.ch[0].req)
    else $error("request flag not cleared at the start");

  // a software request write always raises the flag
  AST_SWSET: assert property (regWr && regAddr == {1'b0, `TCD_R_CTL} && // [R24]
                              regWdata[`TCD_C_SWR] |=> st_q.ch[0].req)
    else $error("software request lost");

  // the first transfer after an enable write reloads counter and pointers
  AST_FRESH: assert property (st_q.fsm == IDLE && st_q.ch[0].en && st_q.ch[0].req && // [R11]
                              st_q.ch[0].fresh && !regWr |=>
                              st_q.ch[0].count == $past(st_q.ch[0].reload) &&
                              st_q.src == $past(st_q.ch[0].srcPtr) &&
                              st_q.dst == $past(st_q.ch[0].dstPtr))
    else $error("first transfer did not reload");

  // a fixed pointer ignores writes while its channel runs
  AST_FIXWR: assert property (regWr && regAddr == {1'b0, `TCD_R_DLO} && // [R12]
                              st_q.ch[0].en && !st_q.ch[0].dInc |=>
                              $stable(st_q.ch[0].dstPtr))
    else $error("fixed pointer written while enabled");

  // past values are used since the width pin may move between transfers
  AST_SPLIT: assert property ($rose(busReq) && $past(bus8) && !$past(regWr) && // [R17]
                              st_q.ch[st_q.cur].u16 |-> st_q.two && !memBus.wide)
    else $error("16-bit unit not split on a byte bus");

  // software wait stretches a write by one cycle
  sequence sWaitWr;
    $rose(memBus.wr) && $past(st_q.ch[st_q.cur].wt);
  endsequence
  AST_WTWR: assert property (sWaitWr |-> memBus.wr [*2]) // [R19]
    else $error("software wait not applied to a write");

  AST_IRQSRC: assert property (dmaIrq != 2'b00 |-> $past(endXfer)) // [R9]
    else $error("interrupt without a finished transfer");

  AST_RDWR: assert property ($fell(memBus.rd) |-> st_q.fsm == WR) // [R15]
    else $error("read strobe ended outside the write phase");
endmodule

//--- testbench/tb_two_channel_cycle_steal_dma.sv
// self-checking bench for the two-channel cycle-steal transfer controller
module tb_two_channel_cycle_steal_dma;
  timeunit 1ns;
  timeprecision 1ps;
  import tcd_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  logic [7:0] periReq = 8'h0;
  logic extIrqPinZero = 1'b1;
  logic extIrqPinOne = 1'b1;
  logic expMode = 1'b0;
  logic byteBus = 1'b0;
  logic [15:0] memRdata;
  tcd_mem_t memBus;
  logic busReq;
  logic [1:0] dmaIrq;
  int bad_count = 0;
  int cmp_count = 0;
  int irqCnt[2] = '{0, 0};
  int riseCnt = 0;
  int busCyc = 0;
  logic busPrev = 1'b0;
  logic [37:0] expQ[$];
  always #4 clock = ~clock;
  tcd_top u_dut (.clock(clock), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .periReq(periReq),
    .extIrqPinZero(extIrqPinZero), .extIrqPinOne(extIrqPinOne), .expMode(expMode),
    .byteBus(byteBus), .memRdata(memRdata), .memBus(memBus), .busReq(busReq),
    .dmaIrq(dmaIrq));
  tcd_mem_model u_mem (.clock(clock), .memBus(memBus), .memRdata(memRdata));
  // registered outputs are counted mid-cycle, away from the launching edge
  always @(negedge clock) begin
    if (dmaIrq[0] === 1'b1) irqCnt[0]++;
    if (dmaIrq[1] === 1'b1) irqCnt[1]++;
    if (busReq === 1'b1) busCyc++;
    if (busReq === 1'b1 && busPrev !== 1'b1) riseCnt++;
    busPrev = busReq;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic regW(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic regChk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk({22'h0, regRdata}, {22'h0, e});
  endtask
  task automatic cfg(input logic ch, input logic [19:0] s, input logic [19:0] d,
                     input logic [15:0] r, input logic [15:0] sl, input logic [15:0] c);
    regW({ch, 3'h0}, s[15:0]);
    regW({ch, 3'h1}, {12'h0, s[19:16]});
    regW({ch, 3'h2}, d[15:0]);
    regW({ch, 3'h3}, {12'h0, d[19:16]});
    regW({ch, 3'h4}, r);
    regW({ch, 3'h7}, sl);
    regW({ch, 3'h6}, c);
  endtask
  // bounded wait until the bus has been quiet for eight cycles
  task automatic settle();
    int n;
    int quiet;
    n = 0;
    quiet = 0;
    repeat (2) @(posedge clock);
    while (quiet < 8 && n < 80) begin
      @(posedge clock);
      #1 n++;
      quiet = (busReq === 1'b0) ? quiet + 1 : 0;
    end
    if (quiet < 8) chk(38'h1, 38'h0);
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    periReq[k] <= 1'b1;
    @(posedge clock);
    periReq <= 8'h0;
    settle();
  endtask
  function automatic void rdE(input logic [19:0] a);
    expQ.push_back({2'b00, a, 16'h0});
  endfunction
  function automatic void wrE(input logic wd, input logic [19:0] a, input logic [15:0] d);
    expQ.push_back({1'b1, wd, a, d});
  endfunction
  task automatic drain();
    chk(38'(u_mem.accLog.size()), 38'(expQ.size()));
    while (expQ.size() > 0 && u_mem.accLog.size() > 0) chk(u_mem.accLog.pop_front(), expQ.pop_front());
    expQ.delete();
    u_mem.accLog.delete();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] r;
    logic [15:0] d16;
    int n0;
    r = 16'($urandom(23297));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 16; i++) regChk(4'(i), 16'h0);
    // high pointer halves keep four bits, the counter ignores writes
    for (int i = 0; i < 5; i++) begin
      r = 16'($urandom());
      regW(4'(i), r);
      regChk(4'(i), (i == 1 || i == 3) ? {12'h0, r[3:0]} : r);
    end
    regW(4'h5, 16'h1234);
    regChk(4'h5, 16'h0);
    regW(4'h6, 16'h0018);
    regChk(4'h6, 16'h0008);
    // single mode, byte units, incrementing source to a fixed destination
    cfg(1'b0, 20'h01000, 20'h02000, 16'h2, 16'h4, 16'h0009);
    for (int k = 0; k < 3; k++) begin
      pulse(0);
      rdE(20'(32'h1000 + k));
      wrE(1'b0, 20'h02000, {8'h0, u_mem.peek(20'(32'h1000 + k))});
      if (k == 0) begin
        regChk(4'h5, 16'h1);
        regChk(4'h0, 16'h1001);
        regW(4'h2, 16'h5555);
        regChk(4'h2, 16'h2000);
      end
    end
    drain();
    chk(38'(irqCnt[0]), 38'h1);
    regChk(4'h6, 16'h0008);
    pulse(0);
    drain();
    regChk(4'h6, 16'h0028);
    regW(4'h6, 16'h0008);
    regChk(4'h6, 16'h0008);
    // repeat mode, word units from an odd fixed source, then an 8-bit bus, then a restart
    cfg(1'b1, 20'h01001, 20'h03000, 16'h1, 16'h5, 16'h0017);
    d16 = {u_mem.peek(20'h01002), u_mem.peek(20'h01001)};
    for (int k = 0; k < 5; k++) begin
      if (k == 2) begin
        @(posedge clock);
        expMode <= 1'b1;
        byteBus <= 1'b1;
      end
      if (k == 4) regW(4'he, 16'h0017);
      pulse(1);
      rdE(20'h01001);
      rdE(20'h01002);
      if (k < 2) wrE(1'b1, 20'(32'h3000 + 2 * k), d16);
      else begin
        wrE(1'b0, 20'(32'h3000 + 2 * (k % 4)), {8'h0, d16[7:0]});
        wrE(1'b0, 20'(32'h3001 + 2 * (k % 4)), {8'h0, d16[15:8]});
      end
    end
    drain();
    chk(38'(irqCnt[1]), 38'h2);
    regChk(4'he, 16'h0017);
    @(posedge clock);
    expMode <= 1'b0;
    byteBus <= 1'b0;
    // both pins fall together: channel zero first, the processor slot between
    regW(4'he, 16'h0);
    cfg(1'b0, 20'h01100, 20'h02100, 16'h0, 16'h1, 16'h0009);
    cfg(1'b1, 20'h01200, 20'h02200, 16'h0, 16'h1, 16'h0009);
    n0 = riseCnt;
    @(posedge clock);
    extIrqPinZero <= 1'b0;
    extIrqPinOne <= 1'b0;
    settle();
    rdE(20'h01100);
    wrE(1'b0, 20'h02100, {8'h0, u_mem.peek(20'h01100)});
    rdE(20'h01200);
    wrE(1'b0, 20'h02200, {8'h0, u_mem.peek(20'h01200)});
    drain();
    chk(38'(riseCnt - n0), 38'h2);
    // software trigger, fixed to fixed, destination inside the own register block
    cfg(1'b0, 20'h01300, 20'h00030, 16'h0, 16'h0, 16'h0041);
    settle();
    rdE(20'h01300);
    drain();
    chk(38'(irqCnt[0]), 38'h3);
    // a peripheral-area source, then software wait on plain memory
    for (int k = 0; k < 2; k++) begin
      n0 = busCyc;
      cfg(1'b0, k ? 20'h01400 : 20'h00100, 20'h02400, 16'h0, 16'h0, k ? 16'h00c1 : 16'h0041);
      settle();
      rdE(k ? 20'h01400 : 20'h00100);
      wrE(1'b0, 20'h02400, {8'h0, u_mem.peek(k ? 20'h01400 : 20'h00100)});
      drain();
      chk(38'(busCyc - n0), 38'(3 + k));
    end
    chk(38'(irqCnt[0]), 38'h5);
    // every peripheral source and the both-edges pin code set the flag while disabled
    for (int k = 0; k < 8; k++) begin
      regW(4'hf, 16'(k + 4));
      pulse(k);
      regChk(4'he, 16'h0028);
      regW(4'he, 16'h0008);
    end
    regW(4'hf, 16'h0002);
    @(posedge clock);
    extIrqPinOne <= 1'b1;
    settle();
    regChk(4'he, 16'h0028);
    chk(38'(irqCnt[1]), 38'h3);
    end_of_test();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    end_of_test();
  end
endmodule

//--- testbench/tcd_mem_model.sv
// memory and processor-side bus model that answers the controller's bus cycles
module tcd_mem_model (
  input wire logic clock,
  input wire tcd_pkg::tcd_mem_t memBus,
  output logic [15:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcd_pkg::*;
  // ----------------------------------------------------------------
  // storage and access log
  // ----------------------------------------------------------------
  logic [7:0] mem[logic [19:0]];
  logic [37:0] accLog[$];
  logic [37:0] key;
  logic [37:0] prevKey = 38'h0;
  logic prevAct = 1'b0;
  logic [15:0] noise = 16'h0;
  // untouched bytes read as a pattern of their address
  function automatic logic [7:0] peek(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ 8'h5a);
  endfunction
  // one log entry per access, byte writes keep only the low lane
  assign key = {memBus.wr, memBus.wide, memBus.addr,
    memBus.wr ? (memBus.wide ? memBus.wdata : {8'h0, memBus.wdata[7:0]}) : 16'h0};
  // outside a read the lines toggle, so a stale sample never looks right
  assign memRdata = memBus.rd ? {peek(memBus.addr + 20'h1), peek(memBus.addr)} : noise;
  // a two-cycle access repeats its key and is logged once
  always @(posedge clock) begin
    noise <= ~noise;
    if ((memBus.rd || memBus.wr) && (!prevAct || key !== prevKey)) begin
      accLog.push_back(key);
      if (memBus.wr) begin
        mem[memBus.addr] = memBus.wdata[7:0];
        if (memBus.wide) mem[memBus.addr + 20'h1] = memBus.wdata[15:8];
      end
    end
    prevAct <= memBus.rd || memBus.wr;
    prevKey <= key;
  end
endmodule
